// File: hw/spkt_consts.svh
`ifndef SPKT_CONSTS_SVH
`define SPKT_CONSTS_SVH
// ==========================================
// Register byte offsets
`define SPKT_ADR_SETUP 8'h00
`define SPKT_ADR_TUNE 8'h04
`define SPKT_ADR_STATUS 8'h08
// ==========================================
// Select codes in the low nibble of the setup and tuning words
`define SPKT_SEL_SETUP 4'h2
`define SPKT_SEL_TUNE 4'h4
`define SPKT_F_SEL 3:0
// ==========================================
// Reset values
`define SPKT_SETUP_RST 16'h2A02
`define SPKT_TUNE_RST 16'h0004
// ==========================================
// Setup word fields
`define SPKT_F_TXTHR 15:14
`define SPKT_F_TAPS 13:12
`define SPKT_F_TX_VOLUME 11:8
`define SPKT_F_RSOFF 7
`define SPKT_F_NCC 6:5
`define SPKT_F_AUTOFF 4
// ==========================================
// Tuning word fields
`define SPKT_F_RXTHR 15:14
`define SPKT_F_RX_SUPPRESS_THRESHOLD 13:12
`define SPKT_F_NRAMP 11:10
`define SPKT_F_HOLDOVER_DELAY 9:8
`define SPKT_F_HOWL_HOLD 7
`define SPKT_F_TXDT 6
`define SPKT_F_RXDT 5
`define SPKT_F_IDLE_TO_TRANSMIT 4
// ==========================================
// Levels, gains, taps and rates
`define SPKT_THR_A_DB 8'h06
`define SPKT_THR_B_DB 8'h09
`define SPKT_THR_C_DB 8'h0C
`define SPKT_RX_SUPP_DB 8'h18
`define SPKT_GAIN_MAX_DB 30
`define SPKT_GAIN_STEP_DB 3
`define SPKT_TX_VOLUME_MUTE 4'hF
`define SPKT_TOTAL_TAPS 9'h1FC
`define SPKT_NW_TAPS_0 9'h040
`define SPKT_NW_TAPS_1 9'h080
`define SPKT_NW_TAPS_2 9'h0C0
`define SPKT_NW_TAPS_3 9'h100
`define SPKT_RAMP_A 4'h3
`define SPKT_RAMP_B 4'h6
`define SPKT_RAMP_C 4'hC
// ==========================================
// Timing
`define SPKT_CLK_KHZ 50000
`define SPKT_HOLD_A_MS 200
`define SPKT_HOLD_B_MS 100
`define SPKT_HOLD_C_MS 150
`endif

// File: hw/spkt_pkg.sv
package spkt_pkg;
  // ==========================================
  // Half-duplex engine states, Gray along idle -> tx -> hold -> rx
  typedef enum logic [1:0] {
    spkt_st_idle = 2'h0,
    spkt_st_tx = 2'h1,
    spkt_st_hold = 2'h3,
    spkt_st_rx = 2'h2
  } spkt_hd_e;
  // ==========================================
  // Network coefficient control codes
  typedef enum logic [1:0] {
    spkt_coef_normal = 2'h0,
    spkt_coef_clear = 2'h1,
    spkt_coef_freeze = 2'h2,
    spkt_coef_rsvd = 2'h3
  } spkt_coef_e;
endpackage : spkt_pkg

// File: hw/spkt_hd_engine.sv
`timescale 1ns/1ps
`default_nettype none
module spkt_hd_engine import spkt_pkg::*; #(
  parameter int HOLD_W = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Speech and control
  input wire logic tx_speech_i,
  input wire logic rx_speech_i,
  input wire logic idle_to_transmit_i,
  input wire logic [HOLD_W-1:0] hold_cyc_i,
  // State
  output spkt_hd_e state_o
);
  typedef struct packed {
    spkt_hd_e st;
    logic owner_rx;
    logic [HOLD_W-1:0] cnt;
  } spkt_eng_s;

  spkt_eng_s r;
  spkt_eng_s n;

  // ==========================================
  // Channel ownership
  always_comb begin
    n = r;
    case (r.st)
      spkt_st_idle: begin
        if (tx_speech_i) begin
          n.st = spkt_st_tx;
        end else if (rx_speech_i) begin
          n.st = spkt_st_rx;
        end else if (idle_to_transmit_i) begin
          n.st = spkt_st_tx;
        end
      end
      spkt_st_tx: begin
        // Auto transmit stays put until the far end has something to say
        if (!tx_speech_i && (rx_speech_i || !idle_to_transmit_i)) begin
          n.st = spkt_st_hold;
          n.owner_rx = 1'b0;
          n.cnt = hold_cyc_i;
        end
      end
      spkt_st_rx: begin
        if (!rx_speech_i) begin
          n.st = spkt_st_hold;
          n.owner_rx = 1'b1;
          n.cnt = hold_cyc_i;
        end
      end
      spkt_st_hold: begin
        // Other channel is ignored here so echoes cannot steal the line
        if (r.owner_rx ? rx_speech_i : tx_speech_i) begin
          n.st = r.owner_rx ? spkt_st_rx : spkt_st_tx;
        end else if (r.cnt <= {{(HOLD_W-1){1'b0}}, 1'b1}) begin
          n.st = spkt_st_idle;
        end else begin
          n.cnt = r.cnt - {{(HOLD_W-1){1'b0}}, 1'b1};
        end
      end
      default: n.st = spkt_st_idle;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '{st: spkt_st_idle, owner_rx: 1'b0, cnt: '0};
    end else begin
      r <= n;
    end
  end

  assign state_o = r.st;

  // ==========================================
  // Checks
  hold_inhibit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.st == spkt_st_hold && r.cnt > 1 && !(r.owner_rx ? rx_speech_i : tx_speech_i))
    |=> (r.st == spkt_st_hold && r.cnt == $past(r.cnt) - 1))
    else $error("holdover ended early or changed owner");
  idle_auto_tx_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.st == spkt_st_idle && idle_to_transmit_i && !rx_speech_i) |=> r.st == spkt_st_tx)
    else $error("idle did not return to transmit");
endmodule : spkt_hd_engine
`default_nettype wire

// File: hw/spkt_tuning_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "spkt_consts.svh"
module spkt_tuning_regs import spkt_pkg::*; #(
  parameter int HOLD_W = 24,
  parameter int HOLD_A_CYC = `SPKT_HOLD_A_MS * `SPKT_CLK_KHZ,
  parameter int HOLD_B_CYC = `SPKT_HOLD_B_MS * `SPKT_CLK_KHZ,
  parameter int HOLD_C_CYC = `SPKT_HOLD_C_MS * `SPKT_CLK_KHZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Power estimates in dB units from the signal path
  input wire logic [7:0] tx_power_i,
  input wire logic [7:0] tx_noise_i,
  input wire logic [7:0] rx_power_i,
  input wire logic [7:0] rx_noise_i,
  // Network path and howl events
  input wire logic net_path_absent_i,
  input wire logic net_path_present_i,
  input wire logic [3:0] network_far_noise_setting_i,
  input wire logic howl_i,
  input wire logic retrain_done_i,
  // Speech detection and suppression
  output logic tx_speech_o,
  output logic rx_speech_o,
  output logic rx_far_speech_o,
  output logic [7:0] rx_atten_db_o,
  // Cancellers
  output logic [8:0] acoustic_taps_o,
  output logic [8:0] network_taps_o,
  output logic network_coef_clear_o,
  output logic network_coef_freeze_o,
  output logic network_canceller_on_o,
  output logic retrain_o,
  // Volume and tracking rates
  output logic signed [7:0] tx_gain_db_o,
  output logic tx_mute_o,
  output logic [3:0] noise_ramp_db_o,
  output logic tx_doubletalk_decay_o,
  output logic rx_doubletalk_decay_o,
  // Half-duplex
  output logic half_duplex_o,
  output spkt_hd_e hd_state_o
);
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [15:0] setup;
    logic [15:0] tune;
    logic tx_sp;
    logic rx_sp;
    logic rx_far;
    logic [7:0] rx_att;
    logic [8:0] ac_taps;
    logic [8:0] nw_taps;
    logic signed [7:0] gain;
    logic mute;
    logic clr;
    logic frz;
    logic net_on;
    logic dropped;
    logic reeng_hd;
    logic howl_hd;
    logic retrain;
    logic hd;
    logic [3:0] ramp;
    logic txdt;
    logic rxdt;
    logic [HOLD_W-1:0] hold_cyc;
  } spkt_regs_s;

  // ==========================================
  // Decoders
  function automatic logic [7:0] spkt_thr(input logic [1:0] code);
    // Reserved code falls back to the reset threshold
    case (code)
      2'h1: spkt_thr = `SPKT_THR_B_DB;
      2'h2: spkt_thr = `SPKT_THR_C_DB;
      default: spkt_thr = `SPKT_THR_A_DB;
    endcase
  endfunction : spkt_thr

  function automatic logic spkt_above(input logic [7:0] pwr, input logic [7:0] flr,
                                      input logic [1:0] code);
    spkt_above = {1'b0, pwr} > ({1'b0, flr} + {1'b0, spkt_thr(code)});
  endfunction : spkt_above

  function automatic logic [8:0] spkt_nw_taps(input logic [1:0] code);
    case (code)
      2'h0: spkt_nw_taps = `SPKT_NW_TAPS_0;
      2'h1: spkt_nw_taps = `SPKT_NW_TAPS_1;
      2'h2: spkt_nw_taps = `SPKT_NW_TAPS_2;
      default: spkt_nw_taps = `SPKT_NW_TAPS_3;
    endcase
  endfunction : spkt_nw_taps

  function automatic logic signed [7:0] spkt_gain(input logic [3:0] code);
    spkt_gain = 8'(`SPKT_GAIN_MAX_DB - `SPKT_GAIN_STEP_DB * int'(code));
  endfunction : spkt_gain

  function automatic logic [15:0] spkt_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] sel, input logic [3:0] code);
    logic [15:0] w;
    w = old;
    if (sel[0]) begin
      w[7:0] = d[7:0];
    end
    if (sel[1]) begin
      w[15:8] = d[15:8];
    end
    // Select nibble is fixed by the word's identity, never by the write
    w[`SPKT_F_SEL] = code;
    spkt_merge = w;
  endfunction : spkt_merge

  localparam logic [HOLD_W-1:0] HOLD_A = HOLD_W'(HOLD_A_CYC);
  localparam logic [HOLD_W-1:0] HOLD_B = HOLD_W'(HOLD_B_CYC);
  localparam logic [HOLD_W-1:0] HOLD_C = HOLD_W'(HOLD_C_CYC);

  localparam spkt_regs_s RST_VAL = '{
    ack: 1'b0, dat: 32'h0000_0000,
    setup: `SPKT_SETUP_RST, tune: `SPKT_TUNE_RST,
    tx_sp: 1'b0, rx_sp: 1'b0, rx_far: 1'b0,
    rx_att: `SPKT_RX_SUPP_DB,
    ac_taps: `SPKT_TOTAL_TAPS - `SPKT_NW_TAPS_2, nw_taps: `SPKT_NW_TAPS_2,
    gain: 8'h00, mute: 1'b0,
    clr: 1'b0, frz: 1'b0, net_on: 1'b1, dropped: 1'b0,
    reeng_hd: 1'b0, howl_hd: 1'b0, retrain: 1'b0, hd: 1'b0,
    ramp: `SPKT_RAMP_A, txdt: 1'b0, rxdt: 1'b0,
    hold_cyc: HOLD_A
  };

  spkt_regs_s r;
  spkt_regs_s n;
  spkt_hd_e eng_state;
  logic bus_req;
  spkt_coef_e coef;

  assign bus_req = cyc_i && stb_i && !r.ack;

  // ==========================================
  // Register file and control
  always_comb begin
    n = r;
    // Bus: answer one cycle after the request, drop ack the cycle after
    n.ack = bus_req;
    n.dat = 32'h0000_0000;
    if (bus_req) begin
      if (adr_i == `SPKT_ADR_SETUP) begin
        if (we_i) begin
          n.setup = spkt_merge(r.setup, dat_i, sel_i, `SPKT_SEL_SETUP);
        end else begin
          n.dat = {16'h0000, r.setup};
        end
      end else if (adr_i == `SPKT_ADR_TUNE) begin
        if (we_i) begin
          n.tune = spkt_merge(r.tune, dat_i, sel_i, `SPKT_SEL_TUNE);
        end else begin
          n.dat = {16'h0000, r.tune};
        end
      end else if (adr_i == `SPKT_ADR_STATUS) begin
        n.dat = {22'h000000, eng_state, r.dropped, r.net_on, r.hd, r.howl_hd,
                 r.reeng_hd, r.rx_far, r.rx_sp, r.tx_sp};
      end
    end

    // Speech detectors
    n.tx_sp = spkt_above(tx_power_i, tx_noise_i, r.setup[`SPKT_F_TXTHR]);
    n.rx_sp = spkt_above(rx_power_i, rx_noise_i, r.tune[`SPKT_F_RXTHR]);
    n.rx_far = spkt_above(rx_power_i, rx_noise_i, r.tune[`SPKT_F_RX_SUPPRESS_THRESHOLD]);
    // Suppression follows the far-end detector, so with RSOFF clear it releases only on activity
    n.rx_att = (!r.setup[`SPKT_F_RSOFF] && !n.rx_far) ? `SPKT_RX_SUPP_DB : 8'h00;

    // Tap split, volume and rates
    n.nw_taps = spkt_nw_taps(r.setup[`SPKT_F_TAPS]);
    n.ac_taps = `SPKT_TOTAL_TAPS - n.nw_taps;
    n.gain = spkt_gain(r.setup[`SPKT_F_TX_VOLUME]);
    n.mute = (r.setup[`SPKT_F_TX_VOLUME] == `SPKT_TX_VOLUME_MUTE);
    case (r.tune[`SPKT_F_NRAMP])
      2'h1: n.ramp = `SPKT_RAMP_B;
      2'h2: n.ramp = `SPKT_RAMP_C;
      default: n.ramp = `SPKT_RAMP_A;
    endcase
    n.txdt = r.tune[`SPKT_F_TXDT];
    n.rxdt = r.tune[`SPKT_F_RXDT];
    case (r.tune[`SPKT_F_HOLDOVER_DELAY])
      2'h1: n.hold_cyc = HOLD_B;
      2'h2: n.hold_cyc = HOLD_C;
      default: n.hold_cyc = HOLD_A;
    endcase

    // Network canceller coefficients and automatic enable
    n.clr = (coef == spkt_coef_clear);
    n.frz = (coef == spkt_coef_freeze);
    n.retrain = 1'b0;
    if (r.dropped && net_path_present_i && !r.setup[`SPKT_F_AUTOFF]) begin
      n.dropped = 1'b0;
      n.retrain = 1'b1;
      n.reeng_hd = 1'b1;
    end else if (net_path_absent_i && network_far_noise_setting_i != 4'h0 && !n.clr) begin
      n.dropped = 1'b1;
    end
    n.net_on = !n.clr && !n.dropped;

    // Half-duplex fallback; a new event wins over a same-cycle clear
    if (retrain_done_i && !n.retrain) begin
      n.reeng_hd = 1'b0;
    end
    if (howl_i) begin
      n.howl_hd = 1'b1;
    end else if (retrain_done_i && !r.tune[`SPKT_F_HOWL_HOLD]) begin
      n.howl_hd = 1'b0;
    end
    // An empty filter cannot cancel, so clear forces half-duplex too
    n.hd = n.reeng_hd || n.howl_hd || n.clr;
  end

  assign coef = spkt_coef_e'(r.setup[`SPKT_F_NCC]);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  // ==========================================
  // Half-duplex engine
  spkt_hd_engine #(
    .HOLD_W(HOLD_W)
  ) u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tx_speech_i(r.tx_sp),
    .rx_speech_i(r.rx_sp),
    .idle_to_transmit_i(r.tune[`SPKT_F_IDLE_TO_TRANSMIT]),
    .hold_cyc_i(r.hold_cyc),
    .state_o(eng_state)
  );

  // ==========================================
  // Outputs
  assign dat_o = r.dat;
  assign ack_o = r.ack;
  assign tx_speech_o = r.tx_sp;
  assign rx_speech_o = r.rx_sp;
  assign rx_far_speech_o = r.rx_far;
  assign rx_atten_db_o = r.rx_att;
  assign acoustic_taps_o = r.ac_taps;
  assign network_taps_o = r.nw_taps;
  assign network_coef_clear_o = r.clr;
  assign network_coef_freeze_o = r.frz;
  assign network_canceller_on_o = r.net_on;
  assign retrain_o = r.retrain;
  assign tx_gain_db_o = r.gain;
  assign tx_mute_o = r.mute;
  assign noise_ramp_db_o = r.ramp;
  assign tx_doubletalk_decay_o = r.txdt;
  assign rx_doubletalk_decay_o = r.rxdt;
  assign half_duplex_o = r.hd;
  assign hd_state_o = eng_state;

  // ==========================================
  // Checks
  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not acknowledged next cycle");
  select_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o && !we_i && adr_i == `SPKT_ADR_TUNE)
    |=> dat_o[3:0] == `SPKT_SEL_TUNE)
    else $error("tuning word select code wrong");
  tx_detect_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_power_i > tx_noise_i + 9'd12) |=> tx_speech_o)
    else $error("tx speech missed above largest threshold");
  tap_total_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (10'(acoustic_taps_o) + 10'(network_taps_o)) == 10'd508)
    else $error("tap split does not cover all taps");
  tx_gain_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(r.setup[11:8]) == 4'hA && $stable(r.setup[11:8]) |-> tx_gain_db_o == 8'sd0)
    else $error("unity volume code not 0 dB");
  rx_suppress_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(r.setup[7]) && !rx_far_speech_o) |-> rx_atten_db_o == 8'd24)
    else $error("rx suppression missing without far speech");
  clear_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    network_coef_clear_o |-> !network_canceller_on_o && half_duplex_o)
    else $error("clear left canceller running");
  drop_noise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(r.dropped) |-> $past(network_far_noise_setting_i) != 4'h0)
    else $error("canceller dropped with zero far noise");
  reengage_a: assert property (@(posedge clk_i) disable iff (rst_i)
    retrain_o |-> network_canceller_on_o || network_coef_freeze_o ##1 !retrain_o)
    else $error("re-engage did not restore canceller");
endmodule : spkt_tuning_regs
`default_nettype wire

// File: testbench/spkt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "spkt_consts.svh"
// ==========================================
// Host microcontroller writing control words over classic Wishbone
module spkt_host_model (
  // Clock
  input wire logic clk_i,
  // Bus answer
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  // Bus request
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // ==========================================
  // One cycle; raw keeps the caller's low nibble so bad codes can be sent
  task automatic xfer(input logic w, raw, input logic [7:0] a, input logic [3:0] s,
                      input logic [15:0] d, output logic [31:0] q, output logic ok);
    logic [15:0] wd;
    wd = d;
    if (!raw) begin
      wd[3:0] = (a == `SPKT_ADR_TUNE) ? `SPKT_SEL_TUNE : `SPKT_SEL_SETUP;
    end
    ok = 1'b0;
    q = 32'h0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= {16'h0000, wd};
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) begin
        ok = 1'b1;
        q = dat_i;
      end
    end
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
  endtask : xfer
endmodule : spkt_host_model
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "spkt_consts.svh"
module testbench import spkt_pkg::*; ;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, absent, present, howl, done;
  logic [7:0] adr, txp, txn, rxp, rxn, att;
  logic [3:0] sel, fns, ramp;
  logic [31:0] wdat, rdat;
  logic txs, rxs, rxf, clr, frz, con, rtr, txd, rxd, hdx, mute;
  logic signed [7:0] gain;
  logic [8:0] ta, tn;
  spkt_hd_e st;
  int bad_count = 0;
  int num_checks = 0;
  // ==========================================
  // Rows: setup word, tuning word, acoustic taps, network taps, ramp
  logic [15:0] su [4] = '{16'h0002, 16'h5122, 16'hAE42, 16'hFF92};
  logic [15:0] tu [4] = '{16'h0004, 16'h5564, 16'hAA04, 16'hFF04};
  logic [8:0] ea [4] = '{9'h1BC, 9'h17C, 9'h13C, 9'h0FC};
  logic [8:0] en [4] = '{9'h040, 9'h080, 9'h0C0, 9'h100};
  logic [3:0] er [4] = '{4'h3, 4'h6, 4'hC, 4'h3};
  always #10 clk_i = ~clk_i;
  spkt_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  spkt_tuning_regs #(.HOLD_A_CYC(20), .HOLD_B_CYC(10), .HOLD_C_CYC(15)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .tx_power_i(txp),
    .tx_noise_i(txn), .rx_power_i(rxp), .rx_noise_i(rxn), .net_path_absent_i(absent),
    .net_path_present_i(present), .network_far_noise_setting_i(fns), .howl_i(howl),
    .retrain_done_i(done), .tx_speech_o(txs), .rx_speech_o(rxs), .rx_far_speech_o(rxf),
    .rx_atten_db_o(att), .acoustic_taps_o(ta), .network_taps_o(tn),
    .network_coef_clear_o(clr), .network_coef_freeze_o(frz), .network_canceller_on_o(con),
    .retrain_o(rtr), .tx_gain_db_o(gain), .tx_mute_o(mute), .noise_ramp_db_o(ramp),
    .tx_doubletalk_decay_o(txd), .rx_doubletalk_decay_o(rxd), .half_duplex_o(hdx),
    .hd_state_o(st));
  // ==========================================
  // Helpers
  task automatic end_of_test();
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, raw, input logic [7:0] a, input logic [3:0] s,
                     input logic [15:0] d, output logic [15:0] q);
    logic [31:0] r;
    logic ok;
    host.xfer(w, raw, a, s, d, r, ok);
    q = r[15:0];
    if (!ok) begin
      bad_count++;
      $display("FAIL %0t no bus answer", $time);
      end_of_test();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, 1'b0, a, 4'h3, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    bus(1'b0, 1'b0, a, 4'h3, 16'h0000, q);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt
  task automatic pulse(input int k);
    @(posedge clk_i);
    absent <= (k == 0);
    present <= (k == 1);
    howl <= (k == 2);
    done <= (k == 3);
    @(posedge clk_i);
    {absent, present, howl, done} <= 4'h0;
  endtask : pulse
  function automatic logic [7:0] thr(input logic [1:0] c);
    return (c == 2'h1) ? 8'h09 : ((c == 2'h2) ? 8'h0C : 8'h06);
  endfunction : thr
  // Noise floors sit at 20 dB; reserved threshold codes act as 6 dB
  task automatic probe(input logic [7:0] tp, rp, input logic [15:0] s, t);
    logic f;
    @(posedge clk_i);
    txp <= tp;
    rxp <= rp;
    wt(2);
    f = rp > 8'h14 + thr(t[13:12]);
    chk(txs, tp > 8'h14 + thr(s[15:14]));
    chk(rxs, rp > 8'h14 + thr(t[15:14]));
    chk(rxf, f);
    chk(att, (f || s[7]) ? 8'h00 : `SPKT_RX_SUPP_DB);
  endtask : probe
  // ==========================================
  // Main sequence
  initial begin
    logic [15:0] q;
    int n;
    txp = 8'h14;
    txn = 8'h14;
    rxp = 8'h14;
    rxn = 8'h14;
    fns = 4'h0;
    {absent, present, howl, done} = 4'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wt(1);
    chk({ta, tn[6:0]}, {9'h13C, 7'h40});
    chk({8'h00, gain}, 16'h0000);
    chk({att, ramp}, {8'h18, 4'h3});
    chk({txd, rxd, clr, frz, con}, 5'h01);
    for (int i = 0; i < 4; i++) begin
      wr(`SPKT_ADR_SETUP, su[i]);
      wr(`SPKT_ADR_TUNE, tu[i]);
      rd(`SPKT_ADR_SETUP, q);
      chk(q, su[i]);
      wt(1);
      chk(ta, ea[i]);
      chk(tn, en[i]);
      chk({8'h00, gain}, {8'h00, 8'h1E - 8'h03 * {4'h0, su[i][11:8]}});
      chk(mute, su[i][11:8] == 4'hF);
      chk({clr, frz}, {su[i][6:5] == 2'h1, su[i][6:5] == 2'h2});
      chk({con, hdx}, {su[i][6:5] != 2'h1, su[i][6:5] == 2'h1});
      chk({ramp, txd, rxd}, {er[i], tu[i][6:5]});
      probe(8'h14 + thr(su[i][15:14]), 8'h14 + thr(tu[i][15:14]), su[i], tu[i]);
      probe(8'h15 + thr(su[i][15:14]), 8'h15 + thr(tu[i][15:14]), su[i], tu[i]);
    end
    // ==========================================
    // Bad select code, single lane, unmapped place
    bus(1'b1, 1'b1, `SPKT_ADR_SETUP, 4'h3, 16'h2A0F, q);
    rd(`SPKT_ADR_SETUP, q);
    chk(q, 16'h2A02);
    bus(1'b1, 1'b0, `SPKT_ADR_SETUP, 4'h2, 16'h1255, q);
    rd(`SPKT_ADR_SETUP, q);
    chk(q, 16'h1202);
    wr(8'h0C, 16'hFFFF);
    rd(8'h0C, q);
    chk(q, 16'h0000);
    // ==========================================
    // Holdover, then idle return to transmit
    wr(`SPKT_ADR_SETUP, 16'h2A02);
    wr(`SPKT_ADR_TUNE, 16'h0104);
    @(posedge clk_i);
    txp <= 8'h28;
    rxp <= 8'h14;
    wt(3);
    chk(st, spkt_st_tx);
    @(posedge clk_i);
    txp <= 8'h14;
    rxp <= 8'h28;
    wt(3);
    n = 0;
    while (st === spkt_st_hold && n < 60) begin
      wt(1);
      n++;
    end
    chk(n >= 7 && n <= 12, 1'b1);
    wt(2);
    chk(st, spkt_st_rx);
    wr(`SPKT_ADR_TUNE, 16'h0114);
    @(posedge clk_i);
    rxp <= 8'h14;
    for (n = 0; n < 40 && st !== spkt_st_tx; n++) wt(1);
    chk(st, spkt_st_tx);
    // ==========================================
    // Network path lost and found again
    pulse(0);
    wt(3);
    chk(con, 1'b1);
    @(posedge clk_i);
    fns <= 4'h3;
    pulse(0);
    wt(3);
    chk(con, 1'b0);
    pulse(1);
    q = 0;
    #1;
    for (n = 0; n < 6; n++) begin
      q = q | rtr;
      wt(1);
    end
    chk({q[0], con, hdx}, 3'h7);
    pulse(3);
    wt(3);
    chk(hdx, 1'b0);
    wr(`SPKT_ADR_SETUP, 16'h2A12);
    pulse(0);
    pulse(1);
    wt(3);
    chk({con, hdx}, 2'h0);
    // ==========================================
    // Howl with and without the hold flag
    pulse(2);
    wt(2);
    chk(hdx, 1'b1);
    pulse(3);
    wt(2);
    chk(hdx, 1'b0);
    wr(`SPKT_ADR_TUNE, 16'h0084);
    pulse(2);
    pulse(3);
    wt(2);
    chk(hdx, 1'b1);
    wr(`SPKT_ADR_TUNE, 16'h0004);
    pulse(3);
    wt(2);
    chk(hdx, 1'b0);
    // ==========================================
    // Second reset in mid-run
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SPKT_ADR_TUNE, q);
    chk(q, 16'h0004);
    rd(`SPKT_ADR_SETUP, q);
    chk(q, `SPKT_SETUP_RST);
    chk(con, 1'b1);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
